// ===== clfm_top.sv
// link fault monitor, range select and path control
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module clfm_top
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       ref_clock_in,
  input  wire logic       mode_hi_in,
  input  wire logic       mode_lo_in,
  input  wire logic       tx_serial_in,
  input  wire logic       rx_line_in,
  input  wire logic       rcv_bit_clk_in,
  input  wire logic       carrier_detect_in,
  input  wire logic       cd_ttl_low_in,
  input  wire logic       cd_open_in,
  input  wire logic       loop_sel_in,
  input  wire logic       pll_unlocked,
  input  wire logic       tx_out_conn,
  input  wire logic       rx_buf_conn,
  input  wire logic       tx_clk_conn,
  input  wire logic       rx_clk_conn,
  input  wire logic       rx_data_conn,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  output logic            tx_bit_clock,
  output logic            tx_line_out,
  output logic            rx_buffer_out,
  output logic            rx_recovered_clk,
  output logic            rx_recovered_data,
  output logic            link_fault_n,
  output logic            range_high,
  output logic            test_mode,
  output logic            tx_pll_en,
  output logic            rx_pll_en,
  output logic            tx_buf_en,
  output logic            rx_buf_en,
  output logic            rx_ref_lock
);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // two-stage synchronisers, stage one read only by stage two
  logic [clfm_pkg::NSYNC-1:0] sy1_ff;
  logic [clfm_pkg::NSYNC-1:0] sy2_ff;
  logic [clfm_pkg::NSYNC-1:0] pins;

  assign pins = {rx_data_conn, rx_clk_conn, tx_clk_conn, rx_buf_conn,
                 tx_out_conn, pll_unlocked, loop_sel_in, cd_open_in, cd_ttl_low_in, carrier_detect_in,
                 rcv_bit_clk_in, rx_line_in, tx_serial_in, mode_lo_in, mode_hi_in, ref_clock_in};

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sy1_ff <= '0;
      sy2_ff <= '0;
    end
    else
    begin
      sy1_ff <= pins;
      sy2_ff <= sy1_ff;
    end
  end

  wire ref_s   = sy2_ff[clfm_pkg::SY_REF];
  wire mhi_s   = sy2_ff[clfm_pkg::SY_MHI];
  wire mlo_s   = sy2_ff[clfm_pkg::SY_MLO];
  wire tx_serial_in_s  = sy2_ff[clfm_pkg::SY_TX_SERIAL_IN];
  wire rin_s   = sy2_ff[clfm_pkg::SY_RIN];
  wire bclk_s  = sy2_ff[clfm_pkg::SY_BCLK];
  wire cd_s    = sy2_ff[clfm_pkg::SY_CD];
  wire cdt_s   = sy2_ff[clfm_pkg::SY_CDT];
  wire cdo_s   = sy2_ff[clfm_pkg::SY_CDO];
  wire loop_s  = sy2_ff[clfm_pkg::SY_LOOP];
  wire ool_s   = sy2_ff[clfm_pkg::SY_OOL];
  wire toc_s   = sy2_ff[clfm_pkg::SY_TOC];
  wire rbc_s   = sy2_ff[clfm_pkg::SY_RBC];
  wire tcc_s   = sy2_ff[clfm_pkg::SY_TCC];
  wire rcc_s   = sy2_ff[clfm_pkg::SY_RCC];
  wire rdc_s   = sy2_ff[clfm_pkg::SY_RDC];

  // three-level mode decode
  wire mode_hi  = mhi_s & ~mlo_s;
  wire mode_lo  = mlo_s & ~mhi_s;
  wire mode_tst = ~mode_hi & ~mode_lo;

  // power-down sensing from output pair connection
  wire tx_buf_on = toc_s;
  wire rx_buf_on = rbc_s;
  wire tx_pll_on = tcc_s;
  wire rx_pll_on = rcc_s | rdc_s;

  // carrier detect classes
  wire ttl_mode = cdt_s | cdo_s;
  wire cd_ecl_low = ~cd_s & ~ttl_mode;
  wire det_en   = ~ttl_mode & rx_pll_on;

  // recovery source: loopback, and vco bypass in test mode
  wire rx_src   = loop_s ? rin_s : tx_serial_in_s;
  wire rx_clk_src = mode_tst ? tx_serial_in_s : bclk_s;

  logic bclk_d_ff;
  logic ref_d_ff;
  wire bit_edge = rise(rx_clk_src, bclk_d_ff) & rx_pll_on;
  wire ref_edge = rise(ref_s, ref_d_ff);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bclk_d_ff <= 1'b0;
      ref_d_ff  <= 1'b0;
    end
    else
    begin
      bclk_d_ff <= rx_clk_src;
      ref_d_ff  <= ref_s;
    end
  end

  // transmit and receive buffer paths, delayed by the synchroniser and one output register
  logic tx_line_ff;
  logic rx_buf_ff;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_line_ff <= 1'b0;
      rx_buf_ff  <= 1'b0;
    end
    else
    begin
      tx_line_ff <= tx_buf_on & tx_serial_in_s;
      rx_buf_ff  <= rx_buf_on & rin_s;
    end
  end
  assign tx_line_out   = tx_line_ff;
  assign rx_buffer_out = rx_buf_ff;

  // transmit multiplier: measure ref period, toggle 16 times per period
  logic [15:0] per_cnt_ff;
  logic [15:0] period_ff;
  logic [16:0] acc_ff;
  logic        tx_bit_clock_ff;
  wire  [15:0] nxt_per_cnt = ref_edge ? 16'h0000 : per_cnt_ff + 16'h0001;
  wire  [16:0] acc_sum = acc_ff + clfm_pkg::TOGGLE_STEP;
  wire         tog     = (period_ff != 16'h0000) & (acc_sum >= {1'b0, period_ff});
  wire  [16:0] nxt_acc = tog ? acc_sum - {1'b0, period_ff} : acc_sum;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      per_cnt_ff <= '0;
      period_ff  <= '0;
    end
    else
    begin
      per_cnt_ff <= nxt_per_cnt;
      if (ref_edge)
        period_ff <= per_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_ff  <= '0;
      tx_bit_clock_ff <= 1'b0;
    end
    else if (!tx_pll_on)
    begin
      acc_ff  <= '0;
      tx_bit_clock_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      if (tog)
        tx_bit_clock_ff <= ~tx_bit_clock_ff;
    end
  end
  assign tx_bit_clock = tx_bit_clock_ff;

  // transition detector
  logic       last_src_ff;
  logic [9:0] quiet_cnt_ff;
  logic       quiet_ff;
  logic [9:0] win_cnt_ff;
  logic [6:0] trans_cnt_ff;
  wire        trans = bit_edge & (rx_src != last_src_ff);

  wire [9:0] nxt_quiet_cnt = (trans | ~det_en) ? 10'h000 :
                             (bit_edge & (quiet_cnt_ff != clfm_pkg::QUIET_BITS)) ?
                             quiet_cnt_ff + 10'h001 : quiet_cnt_ff;
  wire       quiet_hit = det_en & (nxt_quiet_cnt == clfm_pkg::QUIET_BITS);

  wire       win_end   = bit_edge & (win_cnt_ff + 10'h001 == clfm_pkg::WIN_BITS);
  wire [6:0] trans_inc = trans ? trans_cnt_ff + 7'h01 : trans_cnt_ff;
  wire       recover   = quiet_ff & (trans_inc == clfm_pkg::RECOVER_TRANS);
  wire       nxt_quiet = det_en & ((quiet_ff & ~recover) | (quiet_hit & ~quiet_ff));

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_src_ff  <= 1'b0;
      quiet_cnt_ff <= '0;
      quiet_ff     <= 1'b0;
    end
    else
    begin
      if (bit_edge)
        last_src_ff <= rx_src;
      quiet_cnt_ff <= recover ? 10'h000 : nxt_quiet_cnt;
      quiet_ff     <= nxt_quiet;
    end
  end

  // recovery window only runs while the quiet fault stands
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      win_cnt_ff   <= '0;
      trans_cnt_ff <= '0;
    end
    else if (!quiet_ff | recover | win_end)
    begin
      win_cnt_ff   <= '0;
      trans_cnt_ff <= '0;
    end
    else if (bit_edge)
    begin
      win_cnt_ff   <= win_cnt_ff + 10'h001;
      trans_cnt_ff <= trans_inc;
    end
  end

  // out of lock only counts while the receive pll runs
  wire unlocked = ool_s & rx_pll_on;
  wire fault    = cd_ecl_low | quiet_ff | unlocked;
  wire ref_lock = cd_ecl_low | quiet_ff;

  logic lfn_ff;
  logic rclk_ff;
  logic rdata_ff;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lfn_ff   <= 1'b0;
      rclk_ff  <= 1'b0;
      rdata_ff <= 1'b0;
    end
    else
    begin
      lfn_ff  <= ~fault;
      rclk_ff <= rx_pll_on & rx_clk_src;
      if (!rx_pll_on | cd_ecl_low)
        rdata_ff <= 1'b0;
      else if (bit_edge)
        rdata_ff <= rx_src;
    end
  end
  assign link_fault_n      = lfn_ff;
  assign rx_recovered_clk  = rclk_ff;
  assign rx_recovered_data = rdata_ff;

  // status pins registered; they leave the chip and must not glitch
  logic range_ff;
  logic test_ff;
  logic tx_pll_ff;
  logic rx_pll_ff;
  logic tx_bufen_ff;
  logic rx_bufen_ff;
  logic ref_lock_ff;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      range_ff    <= 1'b0;
      test_ff     <= 1'b0;
      tx_pll_ff   <= 1'b0;
      rx_pll_ff   <= 1'b0;
      tx_bufen_ff <= 1'b0;
      rx_bufen_ff <= 1'b0;
      ref_lock_ff <= 1'b0;
    end
    else
    begin
      range_ff    <= mode_hi;
      test_ff     <= mode_tst;
      tx_pll_ff   <= tx_pll_on;
      rx_pll_ff   <= rx_pll_on;
      tx_bufen_ff <= tx_buf_on;
      rx_bufen_ff <= rx_buf_on;
      ref_lock_ff <= ref_lock;
    end
  end
  assign range_high  = range_ff;
  assign test_mode   = test_ff;
  assign tx_pll_en   = tx_pll_ff;
  assign rx_pll_en   = rx_pll_ff;
  assign tx_buf_en   = tx_bufen_ff;
  assign rx_buf_en   = rx_bufen_ff;
  assign rx_ref_lock = ref_lock_ff;

  // event capture: set beats clear in the same cycle
  logic               cdl_d_ff;
  logic               ool_d_ff;
  logic               lfn_d_ff;
  logic [clfm_pkg::NEV-1:0] status_ff;
  logic [7:0]         enable_ff;
  logic [7:0]         rdata_q_ff;
  logic [clfm_pkg::NEV-1:0] ev;

  assign ev[clfm_pkg::EV_CARRIER] = rise(cd_ecl_low, cdl_d_ff);
  assign ev[clfm_pkg::EV_QUIET]   = nxt_quiet & ~quiet_ff;
  assign ev[clfm_pkg::EV_UNLOCK]  = rise(unlocked, ool_d_ff);
  assign ev[clfm_pkg::EV_RECOVER] = rise(lfn_ff, lfn_d_ff);

  wire sel_clear  = reg_wr & (reg_addr == clfm_pkg::REG_CLEAR);
  wire sel_enable = reg_wr & (reg_addr == clfm_pkg::REG_ENABLE);
  wire [clfm_pkg::NEV-1:0] clr_mask = sel_clear ? reg_wdata[clfm_pkg::NEV-1:0] : '0;
  wire [clfm_pkg::NEV-1:0] nxt_status = (status_ff & ~clr_mask) | ev;

  wire [7:0] live = {1'b0,
                     mode_hi,
                     mode_tst,
                     ttl_mode,
                     cd_ecl_low,
                     quiet_ff,
                     unlocked,
                     lfn_ff};
  wire [7:0] rd_mux = (reg_addr == clfm_pkg::REG_STATUS) ? {4'h0, status_ff} :
                      (reg_addr == clfm_pkg::REG_ENABLE) ? enable_ff :
                      (reg_addr == clfm_pkg::REG_LIVE)   ? live : 8'h00;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cdl_d_ff <= 1'b1;                        // carrier reads lost until synced
      ool_d_ff <= 1'b0;
      lfn_d_ff <= 1'b0;
    end
    else
    begin
      cdl_d_ff <= cd_ecl_low;
      ool_d_ff <= unlocked;
      lfn_d_ff <= lfn_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_ff  <= '0;
      enable_ff  <= clfm_pkg::ENABLE_RST;
      rdata_q_ff <= 8'h00;
    end
    else
    begin
      status_ff <= nxt_status;
      if (sel_enable)
        enable_ff <= reg_wdata;
      rdata_q_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q_ff;
  assign irq = |(status_ff & enable_ff[clfm_pkg::NEV-1:0]);

endmodule

// ===== clfm_pkg.sv
// constants and field layout for the link fault monitor
//
// Contract
// - mode high: x8 of 19.44 MHz, 155.52 MHz
// - mode low: x8 of 6.48 MHz, 51.84 MHz
// - mode floating or mid: factory test mode
// - transmit bit clock is reference times eight
// - transmit serial passes unaltered to line out
// - recovered clock drives output and samples data
// - carrier ecl low: fault, ref lock, data low
// - 512 quiet bit times: fault and ref lock
// - 64 transitions within 512 bits clears fault
// - carrier ttl low: only out of lock faults
// - open carrier input acts as ttl low
// - loop low recovers from transmit serial input
// - unconnected output pair turns its buffer off
// - unconnected transmit clock pair powers multiplier down
// - receive pll off, fault still follows carrier
package clfm_pkg;
  localparam int unsigned REF_HI_KHZ   = 19440;
  localparam int unsigned LINE_HI_KHZ  = 155520;
  localparam int unsigned REF_LO_KHZ   = 6480;
  localparam int unsigned LINE_LO_KHZ  = 51840;
  localparam int unsigned PLL_MULT     = 8;
  localparam int unsigned LOCK_PPM     = 1000;
  localparam logic [9:0]  QUIET_BITS   = 10'h200;
  localparam logic [9:0]  WIN_BITS     = 10'h200;
  localparam logic [6:0]  RECOVER_TRANS = 7'h40;
  localparam logic [16:0] TOGGLE_STEP  = 17'h00010;
  // synchroniser bit positions
  localparam int SY_REF  = 0;
  localparam int SY_MHI  = 1;
  localparam int SY_MLO  = 2;
  localparam int SY_TX_SERIAL_IN = 3;
  localparam int SY_RIN  = 4;
  localparam int SY_BCLK = 5;
  localparam int SY_CD   = 6;
  localparam int SY_CDT  = 7;
  localparam int SY_CDO  = 8;
  localparam int SY_LOOP = 9;
  localparam int SY_OOL  = 10;
  localparam int SY_TOC  = 11;
  localparam int SY_RBC  = 12;
  localparam int SY_TCC  = 13;
  localparam int SY_RCC  = 14;
  localparam int SY_RDC  = 15;
  localparam int NSYNC   = 16;
  // register map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CLEAR  = 4'h4;
  localparam logic [3:0] REG_ENABLE = 4'h8;
  localparam logic [3:0] REG_LIVE   = 4'hc;
  // status bits
  localparam int EV_CARRIER = 0;
  localparam int EV_QUIET   = 1;
  localparam int EV_UNLOCK  = 2;
  localparam int EV_RECOVER = 3;
  localparam int NEV        = 4;
  localparam logic [7:0] ENABLE_RST = 8'h00;
endpackage

// ===== clfm_monitor.sv
// assertion checker on the link fault monitor ports
`timescale 1ns/1ns
module clfm_monitor
(
  input logic       ref_clk,
  input logic       rstn,
  input logic       carrier_detect_in,
  input logic       cd_ttl_low_in,
  input logic       cd_open_in,
  input logic       pll_unlocked,
  input logic       mode_hi_in,
  input logic       mode_lo_in,
  input logic       tx_clk_conn,
  input logic       tx_out_conn,
  input logic       rx_clk_conn,
  input logic       rx_data_conn,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       link_fault_n,
  input logic       rx_ref_lock,
  input logic       rx_recovered_data,
  input logic       test_mode,
  input logic       tx_bit_clock,
  input logic       tx_line_out,
  input logic       rx_recovered_clk
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // five samples cover two sync stages plus the output register
  sequence s_cd_lost;
    (!carrier_detect_in && !cd_ttl_low_in && !cd_open_in) [*5];
  endsequence
  property p_cd_fault; s_cd_lost |-> !link_fault_n; endproperty
  property p_cd_hold; s_cd_lost |-> rx_ref_lock && !rx_recovered_data; endproperty
  property p_unlock; (pll_unlocked && (rx_clk_conn || rx_data_conn)) [*5] |-> !link_fault_n; endproperty
  property p_tx_pll; !tx_clk_conn [*5] |-> !tx_bit_clock; endproperty
  property p_tx_buf; !tx_out_conn [*5] |-> !tx_line_out; endproperty
  property p_rx_pll; (!rx_clk_conn && !rx_data_conn) [*5] |-> !rx_recovered_clk; endproperty
  property p_test; (mode_hi_in == mode_lo_in) [*5] |-> test_mode; endproperty
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_cd_fault: assert property (p_cd_fault) else $error("no fault on carrier loss");
  a_cd_hold: assert property (p_cd_hold) else $error("carrier loss hold wrong");
  a_unlock: assert property (p_unlock) else $error("no fault on unlock");
  a_tx_pll: assert property (p_tx_pll) else $error("tx clock while off");
  a_tx_buf: assert property (p_tx_buf) else $error("tx line while off");
  a_rx_pll: assert property (p_rx_pll) else $error("rx clock while off");
  a_test: assert property (p_test) else $error("test mode missing");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule

bind clfm_top clfm_monitor mon
(
  .ref_clk, .rstn, .carrier_detect_in, .cd_ttl_low_in, .cd_open_in, .pll_unlocked, .mode_hi_in, .mode_lo_in,
  .tx_clk_conn, .tx_out_conn, .rx_clk_conn, .rx_data_conn, .reg_rd, .reg_rdata, .link_fault_n, .rx_ref_lock,
  .rx_recovered_data, .test_mode, .tx_bit_clock, .tx_line_out, .rx_recovered_clk
);

// ===== clfm_line_model.sv
// line side model: recovered bit clock, reference, line data
`timescale 1ns/1ns
module clfm_line_model
(
  input  logic quiet,
  output logic bit_clk,
  output logic ref_clock,
  output logic line_data
);
  // free running like an analog loop; odd phase to the system clock
  initial
  begin
    bit_clk = 1'b0;
    #7;
    forever #32 bit_clk = ~bit_clk;
  end
  // byte rate reference, x8 equals the bit rate exactly
  initial
  begin
    ref_clock = 1'b0;
    forever #256 ref_clock = ~ref_clock;
  end
  initial line_data = 1'b0;
  // toggle mid-bit; quiet starves the transition detector
  always @(negedge bit_clk)
    if (!quiet)
      line_data <= ~line_data;
endmodule

// ===== cdr_link_fault_monitor_tb.sv
// self-checking bench for the link fault monitor
`timescale 1ns/1ns
module cdr_link_fault_monitor_tb;
  logic ref_clk, rstn, ref_clock_in, mode_hi_in, mode_lo_in, tx_serial_in, rx_line_in, rcv_bit_clk_in, quiet;
  logic carrier_detect_in, cd_ttl_low_in, cd_open_in, loop_sel_in, pll_unlocked, tx_out_conn, rx_buf_conn;
  logic tx_clk_conn, rx_clk_conn, rx_data_conn, reg_wr, reg_rd, irq, tx_bit_clock, tx_line_out, rx_buffer_out;
  logic rx_recovered_clk, rx_recovered_data, link_fault_n, range_high, test_mode, tx_pll_en, rx_pll_en;
  logic tx_buf_en, rx_buf_en, rx_ref_lock;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, en;
  int error_cnt, tests_run, cyc_cnt, n;
  clfm_top dut
  (
    .ref_clk, .rstn, .ref_clock_in, .mode_hi_in, .mode_lo_in, .tx_serial_in, .rx_line_in, .rcv_bit_clk_in,
    .carrier_detect_in, .cd_ttl_low_in, .cd_open_in, .loop_sel_in, .pll_unlocked, .tx_out_conn, .rx_buf_conn,
    .tx_clk_conn, .rx_clk_conn, .rx_data_conn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .tx_bit_clock, .tx_line_out, .rx_buffer_out, .rx_recovered_clk, .rx_recovered_data, .link_fault_n,
    .range_high, .test_mode, .tx_pll_en, .rx_pll_en, .tx_buf_en, .rx_buf_en, .rx_ref_lock
  );
  clfm_line_model u_line
  (
    .quiet, .bit_clk(rcv_bit_clk_in), .ref_clock(ref_clock_in), .line_data(rx_line_in)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bounded run; a hang counts as a mismatch
  always @(posedge ref_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000)
    begin
      error_cnt++;
      test_done;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // count tx clock rises over k cycles into n
  task automatic rises(input int k);
    logic p;
    p = tx_bit_clock;
    n = 0;
    repeat (k)
    begin
      @(posedge ref_clk);
      #1;
      if (tx_bit_clock && !p)
        n++;
      p = tx_bit_clock;
    end
  endtask
  task automatic wait_lf(input logic lvl, input int lim);
    n = 0;
    while (link_fault_n !== lvl && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(link_fault_n, lvl);
  endtask
  task automatic t_mode;
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      @(posedge ref_clk);
      mode_hi_in <= m[1];
      mode_lo_in <= m[0];
      cyc(5);
      chk(test_mode, m[1] == m[0]);
      chk(range_high, m == 2'b10);
    end
    mode_hi_in <= 1'b1;
    mode_lo_in <= 1'b0;
  endtask
  task automatic t_tx;
    cyc(300);
    chk(tx_pll_en, 1'b1);
    chk(tx_buf_en, 1'b1);
    rises(512);
    chk(n >= 31 && n <= 33, 1'b1);
    tx_serial_in <= 1'b1;
    tx_clk_conn <= 1'b0;
    cyc(5);
    chk(tx_line_out, 1'b1);
    chk(tx_pll_en, 1'b0);
    rises(128);
    chk(n[7:0], 8'h00);
    tx_out_conn <= 1'b0;
    cyc(5);
    chk(tx_line_out, 1'b0);
    chk(tx_buf_en, 1'b0);
    tx_out_conn <= 1'b1;
    tx_clk_conn <= 1'b1;
    tx_serial_in <= 1'b0;
  endtask
  task automatic t_loop;
    // park the line high so the buffer checks below can fail
    while (rx_line_in !== 1'b1)
      @(posedge ref_clk);
    quiet <= 1'b1;
    loop_sel_in <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      tx_serial_in <= rx_line_in ^ i[0];
      cyc(48);
      chk(rx_recovered_data, rx_line_in ^ i[0]);
    end
    loop_sel_in <= 1'b1;
    cyc(48);
    chk(rx_recovered_data, rx_line_in);
    chk(rx_buffer_out, rx_line_in);
    chk(rx_buf_en, 1'b1);
    rx_buf_conn <= 1'b0;
    cyc(5);
    chk(rx_buffer_out, 1'b0);
    chk(rx_buf_en, 1'b0);
    rx_buf_conn <= 1'b1;
    quiet <= 1'b0;
  endtask
  task automatic t_quiet;
    cyc(64);
    quiet <= 1'b1;
    cyc(500 * 16);
    chk(link_fault_n, 1'b1);
    wait_lf(1'b0, 320);
    chk(rx_ref_lock, 1'b1);
    quiet <= 1'b0;
    cyc(40 * 16);
    chk(link_fault_n, 1'b0);
    wait_lf(1'b1, 17600);
  endtask
  task automatic t_carrier;
    en = 8'h01 << clfm_pkg::EV_CARRIER;
    wr(clfm_pkg::REG_CLEAR, 8'hff);
    wr(clfm_pkg::REG_ENABLE, en);
    rdr(clfm_pkg::REG_ENABLE);
    chk(rd, en);
    chk(irq, 1'b0);
    carrier_detect_in <= 1'b0;
    cyc(6);
    chk(link_fault_n, 1'b0);
    chk(rx_ref_lock, 1'b1);
    chk(rx_recovered_data, 1'b0);
    chk(irq, 1'b1);
    rdr(clfm_pkg::REG_STATUS);
    chk(rd & en, en);
    wr(clfm_pkg::REG_ENABLE, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
    wr(clfm_pkg::REG_ENABLE, en);
    n = 0;
    while (rx_recovered_clk !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(rx_recovered_clk, 1'b1);
    rx_clk_conn <= 1'b0;
    cyc(6);
    chk(rx_pll_en, 1'b1);
    rx_data_conn <= 1'b0;
    cyc(6);
    chk(rx_pll_en, 1'b0);
    chk(rx_recovered_clk, 1'b0);
    chk(link_fault_n, 1'b0);
    carrier_detect_in <= 1'b1;
    cyc(6);
    chk(link_fault_n, 1'b1);
    wr(clfm_pkg::REG_CLEAR, en);
    cyc(2);
    chk(irq, 1'b0);
    rdr(4'h2);
    chk(rd, 8'h00);
    rx_clk_conn <= 1'b1;
    rx_data_conn <= 1'b1;
  endtask
  task automatic t_ttl;
    carrier_detect_in <= 1'b0;
    cd_ttl_low_in <= 1'b1;
    quiet <= 1'b1;
    cyc(520 * 16);
    chk(link_fault_n, 1'b1);
    pll_unlocked <= 1'b1;
    cyc(6);
    chk(link_fault_n, 1'b0);
    pll_unlocked <= 1'b0;
    cd_ttl_low_in <= 1'b0;
    cd_open_in <= 1'b1;
    cyc(520 * 16);
    chk(link_fault_n, 1'b1);
  endtask
  initial
  begin
    {rstn, mode_lo_in, tx_serial_in, cd_ttl_low_in, cd_open_in, pll_unlocked, quiet} = 7'h00;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
    {mode_hi_in, loop_sel_in, tx_out_conn, rx_buf_conn, tx_clk_conn, rx_clk_conn, rx_data_conn} = 7'h7f;
    carrier_detect_in = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    cyc_cnt = 0;
    cyc(20);
    rstn <= 1'b1;
    t_mode;
    t_tx;
    t_loop;
    t_quiet;
    t_carrier;
    t_ttl;
    test_done;
  end
endmodule
